// File: inc/ple_pkg.sv
// Package for the PID loop engine: register map, fixed-point constants, types.
package ple_pkg;

   // ==========================================================
   // Fixed-point format: signed Q16.16 in every loop table word
   localparam int FRAC = 16;
   localparam logic signed [31:0] FX_ONE = 32'sh0001_0000;
   localparam logic signed [31:0] FX_HALF = 32'sh0000_8000;
   localparam logic signed [31:0] FX_ZERO = 32'sh0000_0000;
   localparam logic signed [31:0] FX_MAX = 32'sh7FFF_FFFF;
   localparam logic signed [31:0] SEC_PER_MIN = 32'sh0000_003C;

   // ==========================================================
   // Register byte offsets
   localparam logic [7:0] OFF_PV = 8'h00;
   localparam logic [7:0] OFF_SP = 8'h04;
   localparam logic [7:0] OFF_OUT = 8'h08;
   localparam logic [7:0] OFF_GAIN = 8'h0C;
   localparam logic [7:0] OFF_INTERVAL = 8'h10;
   localparam logic [7:0] OFF_IPERIOD = 8'h14;
   localparam logic [7:0] OFF_DPERIOD = 8'h18;
   localparam logic [7:0] OFF_ISUM = 8'h1C;
   localparam logic [7:0] OFF_PREV = 8'h20;
   localparam logic [7:0] OFF_CTRL = 8'h24;
   localparam logic [7:0] OFF_SPAN = 8'h28;
   localparam logic [7:0] OFF_NORM = 8'h2C;
   localparam logic [7:0] OFF_STAT = 8'h30;

   // Register selector codes; 0 to 8 are the loop table words.
   localparam int TBL_WORDS = 9;
   localparam logic [3:0] IDX_PV = 4'h0;
   localparam logic [3:0] IDX_SP = 4'h1;
   localparam logic [3:0] IDX_OUT = 4'h2;
   localparam logic [3:0] IDX_GAIN = 4'h3;
   localparam logic [3:0] IDX_INTERVAL = 4'h4;
   localparam logic [3:0] IDX_IPERIOD = 4'h5;
   localparam logic [3:0] IDX_DPERIOD = 4'h6;
   localparam logic [3:0] IDX_ISUM = 4'h7;
   localparam logic [3:0] IDX_PREV = 4'h8;
   localparam logic [3:0] SEL_CTRL = 4'h9;
   localparam logic [3:0] SEL_SPAN = 4'hA;
   localparam logic [3:0] SEL_NORM = 4'hB;
   localparam logic [3:0] SEL_STAT = 4'hC;
   localparam logic [3:0] SEL_NONE = 4'hF;

   // ==========================================================
   // Field positions and reset values
   localparam int CTRL_IN_BIP = 0;
   localparam int CTRL_OUT_BIP = 1;
   localparam int SPAN_IN_LSB = 0;
   localparam int SPAN_OUT_LSB = 16;
   localparam int STAT_BUSY = 0;
   localparam int STAT_HIST = 1;
   localparam int STAT_ENABLE = 2;
   localparam int STAT_RUN = 3;
   localparam logic [15:0] SPAN_UNI = 16'h7D00;
   localparam logic [15:0] SPAN_BIP = 16'hFA00;
   localparam logic [15:0] SPAN_RST = SPAN_UNI;
   localparam logic [31:0] TBL_RST = 32'h0000_0000;
   localparam logic HIST_RST = 1'b1;
   localparam logic [5:0] DIV_STEPS = 6'h30;

   // ==========================================================
   // Types
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_NORM = 5'h02,
      ST_KI = 5'h04,
      ST_KD = 5'h08,
      ST_CALC = 5'h10
   } ple_fsm_t;

   typedef struct packed {
      logic [47:0] dvd;
      logic [40:0] rem;
      logic [39:0] den;
      logic [5:0] cnt;
      logic neg;
   } ple_div_t;

   typedef struct packed {
      logic [TBL_WORDS-1:0][31:0] tbl;
      logic in_bip;
      logic out_bip;
      logic [15:0] in_span;
      logic [15:0] out_span;
      logic [31:0] norm;
      logic [31:0] ki;
      logic [31:0] kd;
      logic hist;
      logic en_s1;
      logic en_s2;
      logic run_s1;
      logic run_s2;
      logic [15:0] raw_s1;
      logic [15:0] raw_s2;
      ple_fsm_t st;
      ple_div_t dv;
      logic [31:0] prdata;
      logic [15:0] aout;
   } ple_state_t;

endpackage : ple_pkg

// File: core/ple_core.sv
// PID loop engine: APB loop table, normalizer, PID calculation, output scaler.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - Normalized input is raw divided by span, plus 0.0 unipolar or 0.5 bipolar.
// - Span is maximum minus minimum; 32000 unipolar, 64000 bipolar typical.
// - Scaled output is loop output minus offset, times span.
// - Scaled output is truncated to integer; 16-bit value drives analog out.
// - Positive gain acts forward, negative gain acts in reverse.
// - With zero gain, integral and derivative period signs set the action.
// - Calculation reads process value and setpoint; only bumpless transfer alters setpoint, never PV.
// - Each calculation writes loop output clamped to 0.0 through 1.0.
// - Loop output written by software is the starting output for auto.
// - Each calculation updates integral sum; next calculation uses it.
// - Output over 1.0 sets sum to 1.0-(P+D); under 0.0 to -(P+D).
// - Integral sum clamped to 0.0 through 1.0 and written back each calculation.
// - Engine keeps previous process value; software leaves it alone.
// - Calculation only while enable is true: auto; otherwise manual.
// - History bit of previous enable detects a 0-to-1 enable edge.
// - On enable edge copy PV to setpoint and previous PV, output to sum.
// - History bit resets set, and is set again whenever run mode is stop.
// - Enable already true on first run after start gives no transfer.
// - Proportional term is gain times setpoint minus process value.
// - Integral term is gain times interval over period, times error, plus sum.
// - Derivative term is gain times period over interval times PV change.
// - Zero gain uses 1.0 as gain inside integral and derivative terms.
module ple_core
   import ple_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sample_tick,
   input wire logic loop_enable,
   input wire logic run_mode,
   input wire logic [15:0] raw_value,
   output logic [15:0] analog_out,
   output logic busy
);

   // ==========================================================
   // Helper functions
   function automatic logic [31:0] sat32(input logic signed [63:0] v);
      logic [31:0] r;
      if (v > 64'sh0000_0000_7FFF_FFFF) begin
         r = 32'h7FFF_FFFF;
      end else if (v < 64'shFFFF_FFFF_8000_0000) begin
         r = 32'h8000_0000;
      end else begin
         r = v[31:0];
      end
      return r;
   endfunction : sat32

   function automatic logic [31:0] fmul(input logic signed [31:0] a,
                                        input logic signed [31:0] b);
      logic signed [63:0] p;
      p = a * b;
      return sat32(p >>> FRAC);
   endfunction : fmul

   // Minutes to seconds with the sign kept: a negative period must stay
   // negative so that it still reverses the loop when the gain is zero.
   function automatic logic signed [63:0] min_to_sec(input logic [31:0] t);
      return 64'($signed(t)) * 64'(SEC_PER_MIN);
   endfunction : min_to_sec

   function automatic logic [31:0] clamp01(input logic signed [63:0] v);
      logic [31:0] r;
      if (v > 64'(FX_ONE)) begin
         r = FX_ONE;
      end else if (v < 64'sh0) begin
         r = FX_ZERO;
      end else begin
         r = v[31:0];
      end
      return r;
   endfunction : clamp01

   // Quotient is (num << FRAC) / den, signed, in the table's format.
   function automatic ple_div_t div_load(input logic signed [31:0] num,
                                         input logic signed [39:0] den);
      ple_div_t d;
      logic [31:0] nm;
      logic [39:0] dm;
      nm = num[31] ? (~num + 32'h1) : num;
      dm = den[39] ? (~den + 40'h1) : den;
      d.dvd = {nm, 16'h0000};
      d.rem = '0;
      d.den = dm;
      d.cnt = DIV_STEPS;
      d.neg = num[31] ^ den[39];
      return d;
   endfunction : div_load

   // A zero divisor yields all ones, which saturates to full scale.
   function automatic logic [31:0] div_result(input ple_div_t d);
      logic [31:0] q;
      q = (|d.dvd[47:31]) ? FX_MAX : {1'b0, d.dvd[30:0]};
      return d.neg ? (~q + 32'h1) : q;
   endfunction : div_result

   function automatic logic [3:0] reg_sel(input logic [7:0] a);
      logic [3:0] s;
      if (a == OFF_PV) begin
         s = IDX_PV;
      end else if (a == OFF_SP) begin
         s = IDX_SP;
      end else if (a == OFF_OUT) begin
         s = IDX_OUT;
      end else if (a == OFF_GAIN) begin
         s = IDX_GAIN;
      end else if (a == OFF_INTERVAL) begin
         s = IDX_INTERVAL;
      end else if (a == OFF_IPERIOD) begin
         s = IDX_IPERIOD;
      end else if (a == OFF_DPERIOD) begin
         s = IDX_DPERIOD;
      end else if (a == OFF_ISUM) begin
         s = IDX_ISUM;
      end else if (a == OFF_PREV) begin
         s = IDX_PREV;
      end else if (a == OFF_CTRL) begin
         s = SEL_CTRL;
      end else if (a == OFF_SPAN) begin
         s = SEL_SPAN;
      end else if (a == OFF_NORM) begin
         s = SEL_NORM;
      end else if (a == OFF_STAT) begin
         s = SEL_STAT;
      end else begin
         s = SEL_NONE;
      end
      return s;
   endfunction : reg_sel

   // ==========================================================
   // State and combinational working values
   ple_state_t s_reg;
   ple_state_t s_next;

   logic [3:0] sel;
   logic acc;
   logic wr_ok;
   logic bus_err;
   logic [31:0] rd_val;
   logic signed [31:0] pv;
   logic signed [31:0] sp;
   logic signed [31:0] m_in;
   logic signed [31:0] gain;
   logic signed [31:0] kf;
   logic signed [31:0] isum_in;
   logic signed [31:0] prev;
   logic signed [31:0] err;
   logic signed [31:0] mp;
   logic signed [31:0] mi;
   logic signed [31:0] md;
   logic signed [63:0] mpd;
   logic signed [63:0] msum;
   logic signed [63:0] isum_adj;
   logic signed [63:0] iper_sec;
   logic signed [63:0] scal;
   logic signed [63:0] trunc;
   logic edge_seen;

   assign pready = 1'b1;
   assign prdata = s_reg.prdata;
   assign analog_out = s_reg.aout;
   assign busy = (s_reg.st != ST_IDLE);

   // ==========================================================
   // Bus decode
   always_comb begin
      sel = reg_sel(paddr);
      acc = psel & penable;
      bus_err = 1'b0;
      if (sel == SEL_NONE) begin
         bus_err = 1'b1;
      end else if (pwrite && (sel == SEL_NORM || sel == SEL_STAT)) begin
         bus_err = 1'b1;
      end else if (pwrite && sel <= IDX_PREV && busy) begin
         // The engine owns the table while a calculation is in flight.
         bus_err = 1'b1;
      end
      pslverr = acc & bus_err;
      wr_ok = acc & pwrite & ~bus_err;
      rd_val = 32'h0000_0000;
      if (sel <= IDX_PREV) begin
         rd_val = s_reg.tbl[sel];
      end else if (sel == SEL_CTRL) begin
         rd_val[CTRL_IN_BIP] = s_reg.in_bip;
         rd_val[CTRL_OUT_BIP] = s_reg.out_bip;
      end else if (sel == SEL_SPAN) begin
         rd_val = {s_reg.out_span, s_reg.in_span};
      end else if (sel == SEL_NORM) begin
         rd_val = s_reg.norm;
      end else if (sel == SEL_STAT) begin
         rd_val[STAT_BUSY] = busy;
         rd_val[STAT_HIST] = s_reg.hist;
         rd_val[STAT_ENABLE] = s_reg.en_s2;
         rd_val[STAT_RUN] = s_reg.run_s2;
      end
   end

   // ==========================================================
   // Loop arithmetic, from the table words
   always_comb begin
      pv = s_reg.tbl[IDX_PV];
      sp = s_reg.tbl[IDX_SP];
      m_in = s_reg.tbl[IDX_OUT];
      gain = s_reg.tbl[IDX_GAIN];
      isum_in = s_reg.tbl[IDX_ISUM];
      prev = s_reg.tbl[IDX_PREV];
      kf = (gain == FX_ZERO) ? FX_ONE : gain;
      iper_sec = min_to_sec(s_reg.tbl[IDX_IPERIOD]);
      err = sat32(64'(sp) - 64'(pv));
      mp = fmul(gain, err);
      // The product comes back as a plain word; widen it as signed, or a
      // negative integral step would turn into a large positive one.
      mi = sat32(64'($signed(fmul(s_reg.ki, err)))
                 + 64'(isum_in));
      md = fmul(s_reg.kd, sat32(64'(prev) - 64'(pv)));
      mpd = 64'(mp) + 64'(md);
      msum = mpd + 64'(mi);
      // Pulling the sum back to the rail lets the output leave saturation
      // as soon as the error turns, instead of first unwinding the excess.
      if (msum > 64'(FX_ONE)) begin
         isum_adj = 64'(FX_ONE) - mpd;
      end else if (msum < 64'sh0) begin
         isum_adj = -mpd;
      end else begin
         isum_adj = 64'(mi);
      end
      scal = 64'(m_in - (s_reg.out_bip ? FX_HALF : FX_ZERO))
             * $signed({48'h0, s_reg.out_span});
      trunc = scal[63] ? -((-scal) >>> FRAC) : (scal >>> FRAC);
   end

   // ==========================================================
   // Next-state logic
   always_comb begin
      s_next = s_reg;
      edge_seen = 1'b0;
      s_next.en_s1 = loop_enable;
      s_next.en_s2 = s_reg.en_s1;
      s_next.run_s1 = run_mode;
      s_next.run_s2 = s_reg.run_s1;
      // Bits of the raw word may land a cycle apart; the source should
      // hold it steady across a sample tick.
      s_next.raw_s1 = raw_value;
      s_next.raw_s2 = s_reg.raw_s1;
      s_next.aout = trunc[15:0];

      if (psel && !penable) begin
         s_next.prdata = rd_val;
      end
      if (wr_ok) begin
         if (sel <= IDX_PREV) begin
            s_next.tbl[sel] = pwdata;
         end else if (sel == SEL_CTRL) begin
            s_next.in_bip = pwdata[CTRL_IN_BIP];
            s_next.out_bip = pwdata[CTRL_OUT_BIP];
         end else if (sel == SEL_SPAN) begin
            s_next.in_span = pwdata[SPAN_IN_LSB +: 16];
            s_next.out_span = pwdata[SPAN_OUT_LSB +: 16];
         end
      end

      if (!s_reg.run_s2) begin
         s_next.hist = 1'b1;
      end

      // One restoring divider serves all three quotients, a bit a cycle;
      // it trades about 150 cycles per run for a single subtractor.
      if (s_reg.dv.cnt != 6'h00) begin
         s_next.dv.rem = {s_reg.dv.rem[39:0], s_reg.dv.dvd[47]};
         if (s_next.dv.rem >= {1'b0, s_reg.dv.den}) begin
            s_next.dv.rem = s_next.dv.rem - {1'b0, s_reg.dv.den};
            s_next.dv.dvd = {s_reg.dv.dvd[46:0], 1'b1};
         end else begin
            s_next.dv.dvd = {s_reg.dv.dvd[46:0], 1'b0};
         end
         s_next.dv.cnt = s_reg.dv.cnt - 6'h01;
      end

      case (s_reg.st)
         ST_IDLE: begin
            if (sample_tick) begin
               s_next.dv = div_load($signed({{16{s_reg.raw_s2[15]}},
                                             s_reg.raw_s2}),
                                    $signed({24'h0, s_reg.in_span}));
               s_next.st = ST_NORM;
            end
         end
         ST_NORM: begin
            if (s_reg.dv.cnt == 6'h00) begin
               s_next.norm = div_result(s_reg.dv)
                             + (s_reg.in_bip ? FX_HALF : FX_ZERO);
               s_next.st = ST_IDLE;
               if (s_reg.run_s2) begin
                  edge_seen = s_reg.en_s2 & ~s_reg.hist;
                  s_next.hist = s_reg.en_s2;
                  if (edge_seen) begin
                     s_next.tbl[IDX_SP] = pv;
                     s_next.tbl[IDX_PREV] = pv;
                     s_next.tbl[IDX_ISUM] = m_in;
                  end
                  // The edge run goes on to calculate from the new values.
                  if (s_reg.en_s2) begin
                     s_next.dv = div_load(fmul(kf, s_reg.tbl[IDX_INTERVAL]),
                                          iper_sec[39:0]);
                     s_next.st = ST_KI;
                  end
               end
            end
         end
         ST_KI: begin
            if (s_reg.dv.cnt == 6'h00) begin
               s_next.ki = div_result(s_reg.dv);
               s_next.dv = div_load(fmul(kf, sat32(min_to_sec(
                                    s_reg.tbl[IDX_DPERIOD]))),
                                    $signed({{8{s_reg.tbl[IDX_INTERVAL][31]}},
                                             s_reg.tbl[IDX_INTERVAL]}));
               s_next.st = ST_KD;
            end
         end
         ST_KD: begin
            if (s_reg.dv.cnt == 6'h00) begin
               s_next.kd = div_result(s_reg.dv);
               s_next.st = ST_CALC;
            end
         end
         ST_CALC: begin
            s_next.tbl[IDX_OUT] = clamp01(msum);
            s_next.tbl[IDX_ISUM] = clamp01(isum_adj);
            s_next.tbl[IDX_PREV] = pv;
            s_next.st = ST_IDLE;
         end
         default: begin
            s_next.st = ST_IDLE;
         end
      endcase
   end

   // ==========================================================
   // State register
   // Reset sets the history bit, so an enable already high when reset
   // ends is not taken for a manual-to-auto switch.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_reg <= '0;
         s_reg.tbl <= {TBL_WORDS{TBL_RST}};
         s_reg.in_span <= SPAN_RST;
         s_reg.out_span <= SPAN_RST;
         s_reg.hist <= HIST_RST;
         s_reg.st <= ST_IDLE;
      end else begin
         s_reg <= s_next;
      end
   end

endmodule : ple_core

`default_nettype wire

// File: dv/ple_core_asserts.sv
// Checker with concurrent assertions on the PID loop engine ports.
`timescale 1ns/100ps
`default_nettype none
module ple_core_chk
   import ple_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic sample_tick,
   input wire logic [15:0] analog_out,
   input wire logic busy
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   logic acc;
   logic wr;
   assign acc = psel && penable;
   assign wr = acc && pwrite;

   // ==========================================================
   // Bus answers
   chk_ready_const: assert property (pready)
      else $error("pready dropped");
   chk_err_idle: assert property (!acc |-> !pslverr)
      else $error("pslverr outside access phase");
   chk_err_ro: assert property
      (wr && (paddr == 8'h2C || paddr == 8'h30) |-> pslverr)
      else $error("write to read-only word accepted");
   chk_err_hole: assert property
      (acc && paddr > 8'h30 |-> pslverr && prdata == 32'h0000_0000)
      else $error("unmapped access not refused");
   chk_err_busy: assert property
      (wr && busy && $past(busy) && paddr <= 8'h20 |-> pslverr)
      else $error("table write during run accepted");

   // ==========================================================
   // Engine runs
   chk_run_start: assert property (sample_tick && !busy |=> busy)
      else $error("tick did not start a run");
   chk_run_min: assert property ($rose(busy) |-> busy [*8])
      else $error("run ended too early");
   chk_run_end: assert property ($rose(busy) |-> ##[40:300] !busy)
      else $error("run did not finish");
   chk_out_hold: assert property
      (!wr && !$past(wr) && !$past(wr, 2) && !busy && !$past(busy)
       && !$past(busy, 2) |=> $stable(analog_out))
      else $error("analog output moved without cause");
endmodule : ple_core_chk

bind ple_core ple_core_chk chk_u (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .prdata, .pready, .pslverr, .sample_tick,
   .analog_out, .busy);
`default_nettype wire

// File: dv/ple_core_bench.sv
// Self-checking testbench for the PID loop engine.
`timescale 1ns/100ps
`default_nettype none
module ple_core_bench
   import ple_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, sample_tick;
   logic loop_enable, run_mode, pready, pslverr, busy, e;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [15:0] raw_value, analog_out;
   int fail_count = 0;
   int total_checks = 0;

   ple_core dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .sample_tick, .loop_enable,
      .run_mode, .raw_value, .analog_out, .busy);

   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   // ==========================================================
   // Shared tasks
   task check(input logic [31:0] got, input logic [31:0] exp,
              input string m);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: %s got %h want %h", $time, m, got,
                  exp);
      end
   endtask : check

   // One APB transfer; the request holds until pready is seen high.
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task rd(input logic [7:0] a, input logic [31:0] x, input string m);
      apb(1'b0, a, 32'h0000_0000);
      check(q, x, m);
   endtask : rd

   task pulse;
      @(posedge pclk);
      sample_tick <= 1'b1;
      @(posedge pclk);
      sample_tick <= 1'b0;
      @(posedge pclk);
   endtask : pulse

   task run;
      int n;
      n = 0;
      pulse();
      while (busy !== 1'b0 && n < 400) begin
         @(posedge pclk);
         n++;
      end
      check({31'h0, busy}, 32'h0, "run hang");
   endtask : run

   // Pins pass a two-stage synchronizer, so allow a few cycles.
   task pins(input logic en, input logic rm);
      @(posedge pclk);
      loop_enable <= en;
      run_mode <= rm;
      repeat (4) @(posedge pclk);
   endtask : pins

   task aout(input logic [31:0] d, input logic [15:0] x);
      wr(OFF_OUT, d);
      repeat (3) @(posedge pclk);
      check({16'h0, analog_out}, {16'h0, x}, "analog out");
   endtask : aout

   task row(input logic [31:0] g, td, pv, sp, eo, em);
      wr(OFF_GAIN, g);
      wr(OFF_DPERIOD, td);
      wr(OFF_PV, pv);
      wr(OFF_SP, sp);
      run();
      rd(OFF_OUT, eo, "loop output");
      rd(OFF_ISUM, em, "integral sum");
      rd(OFF_PREV, pv, "previous pv");
      rd(OFF_SP, sp, "setpoint");
   endtask : row

   // ==========================================================
   // Scenarios
   task t_reset;
      rd(OFF_SPAN, 32'h7D00_7D00, "span reset");
      rd(OFF_ISUM, 32'h0000_0000, "sum reset");
      apb(1'b0, OFF_STAT, 32'h0000_0000);
      check({31'h0, q[STAT_HIST]}, 32'h1, "history reset");
      apb(1'b0, 8'h34, 32'h0000_0000);
      check({31'h0, e}, 32'h1, "hole refused");
      apb(1'b1, OFF_NORM, 32'h0000_0001);
      check({31'h0, e}, 32'h1, "read-only refused");
      $display("test reset done");
   endtask : t_reset

   task t_norm;
      run();
      rd(OFF_NORM, 32'h0000_8000, "norm unipolar");
      @(posedge pclk);
      raw_value <= 16'hC180;
      wr(OFF_CTRL, 32'h0000_0003);
      wr(OFF_SPAN, 32'hFA00_FA00);
      run();
      rd(OFF_NORM, 32'h0000_4000, "norm bipolar");
      $display("test normalize done");
   endtask : t_norm

   task t_scale;
      aout(32'h0000_4000, 16'hC180);
      wr(OFF_CTRL, 32'h0000_0000);
      wr(OFF_SPAN, 32'h7D00_7D00);
      aout(32'h0000_8000, 16'h3E80);
      aout(32'h0000_0001, 16'h0000);
      aout(32'h0001_0000, 16'h7D00);
      $display("test scale done");
   endtask : t_scale

   task t_bump;
      wr(OFF_OUT, 32'h0000_4000);
      wr(OFF_PV, 32'h0000_8000);
      wr(OFF_SP, 32'h0001_0000);
      wr(OFF_GAIN, 32'h0001_0000);
      wr(OFF_INTERVAL, 32'h003C_0000);
      wr(OFF_IPERIOD, 32'h0001_0000);
      wr(OFF_DPERIOD, 32'h0000_0000);
      wr(OFF_ISUM, 32'h0000_0000);
      run();
      rd(OFF_OUT, 32'h0000_4000, "manual output");
      rd(OFF_SP, 32'h0001_0000, "manual setpoint");
      pins(1'b1, 1'b1);
      pulse();
      apb(1'b1, OFF_PV, 32'h0000_0000);
      check({31'h0, e}, 32'h1, "busy write");
      run();
      rd(OFF_SP, 32'h0000_8000, "edge setpoint");
      rd(OFF_PREV, 32'h0000_8000, "edge previous");
      rd(OFF_ISUM, 32'h0000_4000, "edge sum");
      rd(OFF_OUT, 32'h0000_4000, "edge output");
      rd(OFF_PV, 32'h0000_8000, "pv kept");
      apb(1'b0, OFF_STAT, 32'h0000_0000);
      check({31'h0, q[STAT_HIST]}, 32'h1, "history");
      $display("test bumpless done");
   endtask : t_bump

   task t_pid;
      row(32'h1_0000, 32'h0, 32'h8000, 32'hC000, 32'hC000, 32'h8000);
      row(32'h1_0000, 32'h0, 32'h8000, 32'h1_0000, 32'h1_0000, 32'h8000);
      row(32'h1_0000, 32'h0, 32'h8000, 32'h0, 32'h0, 32'h8000);
      row(32'hFFFF_0000, 32'h0, 32'h8000, 32'h4000, 32'h1_0000, 32'hC000);
      row(32'h0, 32'h1_0000, 32'h4000, 32'h4000, 32'h1_0000, 32'hC000);
      row(32'h0, 32'hFFFF_0000, 32'h8000, 32'h8000, 32'h1_0000,
          32'hC000);
      row(32'h2_0000, 32'h0, 32'h0, 32'h1_0000, 32'h1_0000, 32'h0);
      $display("test pid done");
   endtask : t_pid

   task t_mode;
      pins(1'b1, 1'b0);
      apb(1'b0, OFF_STAT, 32'h0000_0000);
      check({31'h0, q[STAT_HIST]}, 32'h1, "stop history");
      wr(OFF_SP, 32'h0000_0000);
      run();
      rd(OFF_OUT, 32'h0001_0000, "stop output");
      wr(OFF_SP, 32'h0000_2000);
      pins(1'b1, 1'b1);
      run();
      rd(OFF_SP, 32'h0000_2000, "no edge");
      $display("test mode done");
   endtask : t_mode

   task final_report;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : final_report

   // ==========================================================
   // Main sequence and watchdog
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, sample_tick, loop_enable} = 5'h00;
      run_mode = 1'b1;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      raw_value = 16'h3E80;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_norm();
      t_scale();
      t_bump();
      t_pid();
      t_mode();
      final_report();
   end

   initial begin
      repeat (20000) @(posedge pclk);
      fail_count++;
      final_report();
   end
endmodule : ple_core_bench
`default_nettype wire
